//--- logic/calendar_counter_pkg.sv
// Constants, register map and calendar helper functions for the calendar counter chain.
// Assumes an AHB-Lite word bus and registers kept at byte address four times their index.
package calendar_counter_pkg;

  // Register indices; byte address is four times the index
  localparam logic [19:0] IDX_SECONDS = 20'hFFF90;
  localparam logic [19:0] IDX_MINUTES = 20'hFFF91;
  localparam logic [19:0] IDX_HOURS = 20'hFFF92;
  localparam logic [19:0] IDX_DAY = 20'hFFF96;
  localparam logic [19:0] IDX_WEEKDAY = 20'hFFF95;
  localparam logic [19:0] IDX_MONTH = 20'hFFF97;
  localparam logic [19:0] IDX_YEAR = 20'hFFF98;
  localparam logic [19:0] IDX_CTRL_ZERO = 20'hFFF9D;
  localparam logic [19:0] IDX_CTRL_ONE = 20'hFFF9E;

  // Counter slots of the write buffer
  localparam int NUM_COUNTERS = 7;
  localparam int SLOT_SEC = 0;
  localparam int SLOT_MIN = 1;
  localparam int SLOT_HOUR = 2;
  localparam int SLOT_DAY = 3;
  localparam int SLOT_WEEK = 4;
  localparam int SLOT_MONTH = 5;
  localparam int SLOT_YEAR = 6;
  localparam logic [19:0] SLOT_IDX [NUM_COUNTERS] = '{
    IDX_SECONDS, IDX_MINUTES, IDX_HOURS, IDX_DAY, IDX_WEEKDAY, IDX_MONTH, IDX_YEAR};

  // clock_control_zero fields
  localparam int RUN_ENABLE_BIT = 7;
  localparam int HOUR_FORMAT_BIT = 3;
  localparam int PERIOD_LSB = 0;
  // clock_control_one fields
  localparam int ALARM_ENABLE_BIT = 7;
  localparam int ALARM_FLAG_BIT = 4;
  localparam int PERIODIC_FLAG_BIT = 3;
  localparam int WAIT_STATUS_BIT = 1;
  localparam int HOLD_REQUEST_BIT = 0;

  // Reset values
  localparam logic [7:0] SECONDS_RESET = 8'h00;
  localparam logic [7:0] MINUTES_RESET = 8'h00;
  localparam logic [7:0] HOURS_RESET = 8'h12;
  localparam logic [7:0] DAY_RESET = 8'h01;
  localparam logic [7:0] WEEKDAY_RESET = 8'h00;
  localparam logic [7:0] MONTH_RESET = 8'h01;
  localparam logic [7:0] YEAR_RESET = 8'h00;

  // Prescaler and BCD limits
  localparam logic [15:0] PRESCALE_TOP = 16'h7FFF;
  localparam logic [15:0] PRESCALE_HALF = 16'h3FFF;
  localparam logic [7:0] BCD_59 = 8'h59;
  localparam logic [7:0] BCD_06 = 8'h06;
  localparam logic [7:0] BCD_12 = 8'h12;
  localparam logic [7:0] BCD_99 = 8'h99;
  localparam logic [4:0] HOUR_LAST = 5'h17;

  typedef enum logic [2:0] {
    PER_NONE = 3'b000,
    PER_HALF_SEC = 3'b001,
    PER_SECOND = 3'b010,
    PER_MINUTE = 3'b011,
    PER_HOUR = 3'b100,
    PER_DAY = 3'b101,
    PER_MONTH = 3'b110,
    PER_MONTH_ALT = 3'b111
  } period_sel_t;

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      return {v[7:4] + 4'h1, 4'h0};
    end
    return {v[7:4], v[3:0] + 4'h1};
  endfunction

  function automatic logic [7:0] bin_to_bcd(input logic [4:0] b);
    if (b >= 5'h14) begin
      return {4'h2, 4'(b - 5'h14)};
    end else if (b >= 5'h0A) begin
      return {4'h1, 4'(b - 5'h0A)};
    end
    return {4'h0, b[3:0]};
  endfunction

  // Hour register to binary 0..23
  function automatic logic [4:0] hour_to_bin(input logic [7:0] h, input logic fmt24);
    logic [4:0] base;
    base = 5'(h[3:0]) + (h[4] ? 5'h0A : 5'h00);
    if (fmt24) begin
      return base + (h[5] ? 5'h14 : 5'h00);
    end else if (base == 5'h0C) begin
      return h[5] ? 5'h0C : 5'h00;
    end
    return h[5] ? base + 5'h0C : base;
  endfunction

  // Binary 0..23 to hour register encoding
  function automatic logic [7:0] bin_to_hour(input logic [4:0] b, input logic fmt24);
    if (fmt24) begin
      return bin_to_bcd(b);
    end else if (b == 5'h00) begin
      return 8'h12;
    end else if (b < 5'h0C) begin
      return bin_to_bcd(b);
    end else if (b == 5'h0C) begin
      return 8'h32;
    end
    return bin_to_bcd(b - 5'h0C) | 8'h20;
  endfunction

  function automatic logic is_leap(input logic [7:0] y);
    if (y[4]) begin
      return (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
    end
    return (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
  endfunction

  function automatic logic [7:0] month_len(input logic [7:0] m, input logic [7:0] y);
    unique case (m)
      8'h02: return is_leap(y) ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
      default: return 8'h31;
    endcase
  endfunction

endpackage

//--- logic/calendar_counter_chain.sv
// Calendar counter chain: prescaler, BCD time/date counters, hold handshake, status flags.
// Assumes an AHB-Lite master on hclk and a count clock pin that is slow against hclk.
//
// Summary of operation
// R1 - With alarm matching enabled, alarm flag sets one count tick after a match.
// R2 - Every periodic event sets the periodic flag.
// R3 - Writing 0 clears either flag; writing 1 leaves it alone.
// R4 - Wait status reads 0 while counting, 1 once the hold is in effect.
// R5 - Hold request freezes seconds through year; prescaler keeps running.
// R6 - Software ends its access and drops the hold within one second.
// R7 - Wait status rises within one count tick of the hold request.
// R8 - After run enable or standby exit, wait status may take two ticks.
// R9 - Overflow during hold advances seconds afterwards, unless seconds were written.
// R10 - Any write to seconds clears the prescaler.
// R11 - Software writes control one whole, with ones at both flag bits.
// R12 - Periodic and alarm events share the single interrupt request.
// R13 - Seconds count BCD 00 to 59 on every prescaler overflow.
// R14 - Counter writes go to a buffer and land within two count ticks.
// R15 - A buffered write beats a carry arriving in the same tick.
// R16 - Minutes count BCD 00 to 59 when seconds wrap.
// R17 - Hours use 00-23, or 12-hour codes with bit 5 marking p.m.
// R18 - Changing hour format converts the current hour value.
// R19 - Hours reset to 12H, reading 00H once 24-hour format is chosen.
// R20 - Day counts from 01 to the current month length, on hour wrap.
// R21 - Years that are multiples of four are leap years.
// R22 - Weekday counts 0 to 6 with the day; software must load it.
// R23 - The chain advances only while run enable is 1.
// R24 - Alarm matching happens only while alarm enable is 1.
module calendar_counter_chain
  import calendar_counter_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic count_clock,
  input wire logic alarm_time_match,
  output logic clock_event_irq,
  output logic [7:0] cur_minutes,
  output logic [7:0] cur_hours,
  output logic [7:0] cur_weekday
);

  logic [7:0] seconds_count;
  logic [7:0] minutes_count;
  logic [7:0] hours_count;
  logic [7:0] day_count;
  logic [7:0] weekday_count;
  logic [7:0] month_count;
  logic [7:0] years_count;
  logic counter_run_enable;
  logic hour_format_select;
  logic [2:0] period_select;
  logic alarm_match_enable;
  logic alarm_match_flag;
  logic periodic_irq_flag;
  logic wait_status;
  logic counter_hold_request;

  // Bus side
  logic dphase_write;
  logic [19:0] dphase_idx;
  logic addr_ok;
  logic [7:0] rd_byte;
  logic [7:0] wbyte;
  logic wr_ctrl_zero;
  logic wr_ctrl_one;
  logic [NUM_COUNTERS-1:0] wr_cnt;

  function automatic logic idx_hit(input logic [19:0] idx, input logic [19:0] target);
    return idx == target;
  endfunction

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign addr_ok = hsel && htrans[1] && hready && (haddr[31:22] == 10'h000);
  assign wbyte = hwdata[7:0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dphase_write <= 1'b0;
      dphase_idx <= 20'h00000;
    end else if (hready) begin
      dphase_write <= addr_ok && hwrite;
      dphase_idx <= haddr[21:2];
    end
  end

  always_comb begin
    rd_byte = 8'h00;
    if (idx_hit(haddr[21:2], IDX_SECONDS)) rd_byte = seconds_count;
    if (idx_hit(haddr[21:2], IDX_MINUTES)) rd_byte = minutes_count;
    if (idx_hit(haddr[21:2], IDX_HOURS)) rd_byte = hours_count;
    if (idx_hit(haddr[21:2], IDX_DAY)) rd_byte = day_count;
    if (idx_hit(haddr[21:2], IDX_WEEKDAY)) rd_byte = weekday_count;
    if (idx_hit(haddr[21:2], IDX_MONTH)) rd_byte = month_count;
    if (idx_hit(haddr[21:2], IDX_YEAR)) rd_byte = years_count;
    if (idx_hit(haddr[21:2], IDX_CTRL_ZERO)) begin
      rd_byte[RUN_ENABLE_BIT] = counter_run_enable;
      rd_byte[HOUR_FORMAT_BIT] = hour_format_select;
      rd_byte[PERIOD_LSB +: 3] = period_select;
    end
    if (idx_hit(haddr[21:2], IDX_CTRL_ONE)) begin
      rd_byte[ALARM_ENABLE_BIT] = alarm_match_enable;
      rd_byte[ALARM_FLAG_BIT] = alarm_match_flag;
      rd_byte[PERIODIC_FLAG_BIT] = periodic_irq_flag;
      rd_byte[WAIT_STATUS_BIT] = wait_status; // R4
      rd_byte[HOLD_REQUEST_BIT] = counter_hold_request;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (addr_ok && !hwrite) begin
      hrdata <= {24'h000000, rd_byte};
    end
  end

  assign wr_ctrl_zero = dphase_write && idx_hit(dphase_idx, IDX_CTRL_ZERO);
  assign wr_ctrl_one = dphase_write && idx_hit(dphase_idx, IDX_CTRL_ONE);

  // Count clock pin synchroniser and tick
  logic cc_meta;
  logic cc_sync;
  logic cc_prev;
  logic tick;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cc_meta <= 1'b0;
      cc_sync <= 1'b0;
      cc_prev <= 1'b0;
    end else begin
      cc_meta <= count_clock;
      cc_sync <= cc_meta;
      cc_prev <= cc_sync;
    end
  end

  assign tick = cc_sync && !cc_prev;

  // Write buffer, one slot per counter
  logic [NUM_COUNTERS-1:0] pend_valid;
  logic [7:0] pend_data [NUM_COUNTERS];
  logic [NUM_COUNTERS-1:0] load;

  generate
    for (genvar i = 0; i < NUM_COUNTERS; i++) begin : g_wbuf
      assign wr_cnt[i] = dphase_write && idx_hit(dphase_idx, SLOT_IDX[i]);
      assign load[i] = tick && pend_valid[i];
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          pend_valid[i] <= 1'b0;
          pend_data[i] <= 8'h00;
        end else if (wr_cnt[i]) begin
          pend_valid[i] <= 1'b1; // R14
          pend_data[i] <= wbyte;
        end else if (tick) begin
          pend_valid[i] <= 1'b0;
        end
      end
    end
  endgenerate

  // Control zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      counter_run_enable <= 1'b0;
      hour_format_select <= 1'b0;
      period_select <= 3'b000;
    end else if (wr_ctrl_zero) begin
      counter_run_enable <= wbyte[RUN_ENABLE_BIT];
      hour_format_select <= wbyte[HOUR_FORMAT_BIT];
      period_select <= wbyte[PERIOD_LSB +: 3];
    end
  end

  // Control one, writable bits
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alarm_match_enable <= 1'b0;
      counter_hold_request <= 1'b0;
    end else if (wr_ctrl_one) begin
      alarm_match_enable <= wbyte[ALARM_ENABLE_BIT];
      counter_hold_request <= wbyte[HOLD_REQUEST_BIT];
    end
  end

  // Hold handshake, follows request at the next count tick
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wait_status <= 1'b0;
    end else if (tick) begin
      wait_status <= counter_hold_request; // R4 R7 R8
    end
  end

  // Prescaler
  logic [15:0] prescaler;
  logic ovf;
  logic half;
  logic ov_pending;
  logic adv;

  assign ovf = tick && counter_run_enable && (prescaler == PRESCALE_TOP);
  assign half = tick && counter_run_enable && (prescaler == PRESCALE_HALF);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prescaler <= 16'h0000;
    end else if (wr_cnt[SLOT_SEC]) begin
      prescaler <= 16'h0000; // R10
    end else if (tick && counter_run_enable) begin
      prescaler <= ovf ? 16'h0000 : prescaler + 16'h0001; // R5
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ov_pending <= 1'b0;
    end else if (wr_cnt[SLOT_SEC] || load[SLOT_SEC]) begin
      ov_pending <= 1'b0; // R9
    end else if (ovf && counter_hold_request) begin
      ov_pending <= 1'b1; // R9
    end else if (adv) begin
      ov_pending <= 1'b0;
    end
  end

  // Carry chain
  logic [4:0] hour_bin;
  logic sec_wrap;
  logic min_wrap;
  logic hour_wrap;
  logic day_wrap;
  logic month_wrap;

  assign adv = tick && counter_run_enable && !counter_hold_request && (ovf || ov_pending); // R5 R23
  assign hour_bin = hour_to_bin(hours_count, hour_format_select);
  assign sec_wrap = adv && (seconds_count == BCD_59);
  assign min_wrap = sec_wrap && (minutes_count == BCD_59);
  assign hour_wrap = min_wrap && (hour_bin == HOUR_LAST);
  assign day_wrap = hour_wrap && (day_count == month_len(month_count, years_count));
  assign month_wrap = day_wrap && (month_count == BCD_12);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seconds_count <= SECONDS_RESET;
    end else if (load[SLOT_SEC]) begin
      seconds_count <= pend_data[SLOT_SEC];
    end else if (adv) begin
      seconds_count <= sec_wrap ? 8'h00 : bcd_inc(seconds_count); // R13
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      minutes_count <= MINUTES_RESET;
    end else if (load[SLOT_MIN]) begin
      minutes_count <= pend_data[SLOT_MIN]; // R15
    end else if (sec_wrap) begin
      minutes_count <= min_wrap ? 8'h00 : bcd_inc(minutes_count); // R16
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hours_count <= HOURS_RESET; // R19
    end else if (load[SLOT_HOUR]) begin
      hours_count <= pend_data[SLOT_HOUR]; // R15
    end else if (wr_ctrl_zero && (wbyte[HOUR_FORMAT_BIT] != hour_format_select)) begin
      hours_count <= bin_to_hour(hour_bin, wbyte[HOUR_FORMAT_BIT]); // R18 R19
    end else if (min_wrap) begin
      hours_count <= bin_to_hour(hour_wrap ? 5'h00 : hour_bin + 5'h01,
        hour_format_select); // R17
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      day_count <= DAY_RESET;
    end else if (load[SLOT_DAY]) begin
      day_count <= pend_data[SLOT_DAY]; // R15
    end else if (hour_wrap) begin
      day_count <= day_wrap ? 8'h01 : bcd_inc(day_count); // R20 R21
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      weekday_count <= WEEKDAY_RESET;
    end else if (load[SLOT_WEEK]) begin
      weekday_count <= pend_data[SLOT_WEEK];
    end else if (hour_wrap) begin
      weekday_count <= (weekday_count == BCD_06) ? 8'h00 : weekday_count + 8'h01; // R22
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      month_count <= MONTH_RESET;
    end else if (load[SLOT_MONTH]) begin
      month_count <= pend_data[SLOT_MONTH]; // R15
    end else if (day_wrap) begin
      month_count <= month_wrap ? 8'h01 : bcd_inc(month_count);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      years_count <= YEAR_RESET;
    end else if (load[SLOT_YEAR]) begin
      years_count <= pend_data[SLOT_YEAR]; // R15
    end else if (month_wrap) begin
      years_count <= (years_count == BCD_99) ? 8'h00 : bcd_inc(years_count);
    end
  end

  // Periodic event select
  logic periodic_evt;

  always_comb begin
    unique case (period_sel_t'(period_select))
      PER_NONE: periodic_evt = 1'b0;
      PER_HALF_SEC: periodic_evt = half || adv;
      PER_SECOND: periodic_evt = adv;
      PER_MINUTE: periodic_evt = sec_wrap;
      PER_HOUR: periodic_evt = min_wrap;
      PER_DAY: periodic_evt = hour_wrap;
      PER_MONTH, PER_MONTH_ALT: periodic_evt = day_wrap;
    endcase
  end

  // Alarm detection, flag follows one count tick later
  logic alarm_det;
  logic alarm_det_prev;
  logic alarm_set;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alarm_det <= 1'b0;
      alarm_det_prev <= 1'b0;
    end else if (tick) begin
      alarm_det <= alarm_match_enable && alarm_time_match; // R24
      alarm_det_prev <= alarm_det;
    end
  end

  assign alarm_set = tick && alarm_match_enable && alarm_det && !alarm_det_prev; // R1

  // Status flags, a set beats a clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alarm_match_flag <= 1'b0;
    end else if (alarm_set) begin
      alarm_match_flag <= 1'b1; // R1
    end else if (wr_ctrl_one && !wbyte[ALARM_FLAG_BIT]) begin
      alarm_match_flag <= 1'b0; // R3
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      periodic_irq_flag <= 1'b0;
    end else if (periodic_evt) begin
      periodic_irq_flag <= 1'b1; // R2
    end else if (wr_ctrl_one && !wbyte[PERIODIC_FLAG_BIT]) begin
      periodic_irq_flag <= 1'b0; // R3
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clock_event_irq <= 1'b0;
    end else begin
      clock_event_irq <= periodic_evt || alarm_set; // R12
    end
  end

  assign cur_minutes = minutes_count;
  assign cur_hours = hours_count;
  assign cur_weekday = weekday_count;

endmodule // calendar_counter_chain

//--- test/calendar_counter_chain_assertions.sv
// Checker for the calendar counter chain: bus answer, interrupt pulse and counter outputs.
// Assumes the count clock pin is far slower than hclk and is bound to the design's top ports.
module calendar_counter_chain_assertions (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic count_clock,
  input wire logic clock_event_irq,
  input wire logic [7:0] cur_minutes,
  input wire logic [7:0] cur_hours,
  input wire logic [7:0] cur_weekday
);
  logic cc_q;
  logic [4:0] since_rise;

  // Cycles since the count clock pin last rose
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cc_q <= 1'b0;
      since_rise <= 5'h1F;
    end else begin
      cc_q <= count_clock;
      if (count_clock && !cc_q) begin
        since_rise <= 5'h00;
      end else if (since_rise != 5'h1F) begin
        since_rise <= since_rise + 5'h01;
      end
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_irq_pulse;
    clock_event_irq |=> !clock_event_irq;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse)
    else $error("interrupt request longer than one cycle");
  property p_irq_on_tick;
    $rose(clock_event_irq) |-> since_rise <= 5'h08;
  endproperty
  a_irq_on_tick: assert property (p_irq_on_tick)
    else $error("interrupt request away from a count tick");
  property p_min_on_tick;
    $changed(cur_minutes) |-> since_rise <= 5'h08;
  endproperty
  a_min_on_tick: assert property (p_min_on_tick)
    else $error("minutes changed away from a count tick");
  property p_week_on_tick;
    $changed(cur_weekday) |-> since_rise <= 5'h08;
  endproperty
  a_week_on_tick: assert property (p_week_on_tick)
    else $error("weekday changed away from a count tick");
  property p_min_bcd;
    cur_minutes[3:0] <= 4'h9 && cur_minutes <= 8'h59;
  endproperty
  a_min_bcd: assert property (p_min_bcd)
    else $error("minutes outside BCD 00 to 59");
  property p_hour_code;
    cur_hours[3:0] <= 4'h9 && cur_hours <= 8'h32;
  endproperty
  a_hour_code: assert property (p_hour_code)
    else $error("hours outside legal encoding");
  property p_hour_reset;
    $rose(hresetn) |-> cur_hours == 8'h12;
  endproperty
  a_hour_reset: assert property (p_hour_reset)
    else $error("hours not 12H after reset");
  property p_week_range;
    cur_weekday <= 8'h06;
  endproperty
  a_week_range: assert property (p_week_range)
    else $error("weekday above 6");
  property p_okay;
    hresp == 1'b0 && hreadyout == 1'b1;
  endproperty
  a_okay: assert property (p_okay)
    else $error("bus answer not zero-wait OKAY");

  c_irq: cover property ($rose(clock_event_irq));
  c_minutes: cover property ($changed(cur_minutes));
  c_hours: cover property ($changed(cur_hours));
endmodule // calendar_counter_chain_assertions

bind calendar_counter_chain calendar_counter_chain_assertions calendar_counter_chain_assertions_i (
  .hclk(hclk),
  .hresetn(hresetn),
  .hreadyout(hreadyout),
  .hresp(hresp),
  .count_clock(count_clock),
  .clock_event_irq(clock_event_irq),
  .cur_minutes(cur_minutes),
  .cur_hours(cur_hours),
  .cur_weekday(cur_weekday)
);

//--- test/testbench.sv
// Self-checking bench for the calendar counter chain over AHB-Lite single word transfers.
// Assumes a zero-wait OKAY slave; the count clock pin toggles every cc_half hclk cycles.
module testbench
  import calendar_counter_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic hclk, hresetn, hsel, hwrite, count_clock, alarm_time_match;
  logic [31:0] haddr, hwdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  wire logic hready, hreadyout, hresp, clock_event_irq;
  wire logic [31:0] hrdata;
  wire logic [7:0] cur_minutes, cur_hours, cur_weekday;
  int err_count = 0;
  int checked = 0;
  int irq_count = 0;
  int cc_half = 8;
  logic [7:0] rst_val [7] = '{8'h00, 8'h00, 8'h12, 8'h01, 8'h00, 8'h01, 8'h00};
  logic [7:0] cval [7] = '{8'h30, 8'h59, 8'h00, 8'h29, 8'h06, 8'h02, 8'h96};
  logic [7:0] h12 [6] = '{8'h12, 8'h01, 8'h11, 8'h32, 8'h21, 8'h31};
  logic [7:0] h24 [6] = '{8'h00, 8'h01, 8'h11, 8'h12, 8'h13, 8'h23};
  logic [7:0] nval [7] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h03, 8'h96};

  assign hready = hreadyout;

  calendar_counter_chain calendar_counter_chain_i (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .count_clock(count_clock),
    .alarm_time_match(alarm_time_match),
    .clock_event_irq(clock_event_irq),
    .cur_minutes(cur_minutes),
    .cur_hours(cur_hours),
    .cur_weekday(cur_weekday)
  );

  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  initial begin
    count_clock = 1'b0;
    forever begin
      repeat (cc_half) @(posedge hclk);
      count_clock <= ~count_clock;
    end
  end

  always @(posedge hclk) begin
    if (clock_event_irq === 1'b1) begin
      irq_count++;
    end
  end

  task automatic results();
    if (err_count == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge hclk);
    while (hready !== 1'b1) begin
      n++;
      if (n > 40) begin
        err_count++;
        results();
      end
      @(posedge hclk);
    end
  endtask

  // One single word transfer; entered and left just after a rising edge
  task automatic bus(input logic wr, input logic [19:0] idx, input logic [7:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {10'h000, idx, 2'b00};
    wait_ready();
    htrans <= 2'b00;
    hwdata <= {24'h000000, wd};
    wait_ready();
    rd = hrdata;
  endtask

  task automatic wr(input logic [19:0] idx, input logic [7:0] d);
    logic [31:0] x;
    bus(1'b1, idx, d, x);
  endtask

  task automatic rd_chk(input logic [19:0] idx, input logic [7:0] exp);
    logic [31:0] x;
    bus(1'b0, idx, 8'h00, x);
    check(x, {24'h000000, exp});
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask

  // Poll wait status; about one count clock period plus synchroniser delay
  task automatic poll_wait(input logic want);
    logic [31:0] x;
    int n;
    n = 0;
    do begin
      bus(1'b0, IDX_CTRL_ONE, 8'h00, x);
      n++;
    end while (x[WAIT_STATUS_BIT] !== want && n < 11);
    check({31'h0, x[WAIT_STATUS_BIT]}, {31'h0, want});
  endtask

  initial begin
    repeat (100000) @(posedge hclk);
    err_count++;
    results();
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'b00;
    hwrite = 1'b0;
    haddr = 32'h00000000;
    hwdata = 32'h00000000;
    hsize = 3'b010;
    alarm_time_match = 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check({24'h000000, cur_hours}, 32'h00000012);
    for (int i = 0; i < NUM_COUNTERS; i++) begin
      rd_chk(SLOT_IDX[i], rst_val[i]);
    end
    rd_chk(IDX_CTRL_ONE, 8'h00);
    rd_chk(20'hFFF99, 8'h00);
    wr(20'hFFF99, 8'h5A);
    rd_chk(20'hFFF99, 8'h00);
    // 24-hour format straight after reset
    wr(IDX_CTRL_ZERO, 8'h08);
    rd_chk(IDX_HOURS, 8'h00);
    check({24'h000000, cur_hours}, 32'h00000000);
    // Hour encodings converted both ways
    for (int i = 0; i < 6; i++) begin
      wr(IDX_CTRL_ZERO, 8'h00);
      wr(IDX_HOURS, h12[i]);
      wait_cyc(48);
      wr(IDX_CTRL_ZERO, 8'h08);
      rd_chk(IDX_HOURS, h24[i]);
      wr(IDX_HOURS, h24[i]);
      wait_cyc(48);
      wr(IDX_CTRL_ZERO, 8'h00);
      rd_chk(IDX_HOURS, h12[i]);
      check({24'h000000, cur_hours}, {24'h000000, h12[i]});
    end
    // Buffered counter writes under hold
    wr(IDX_CTRL_ONE, 8'h19);
    poll_wait(1'b1);
    rd_chk(IDX_CTRL_ONE, 8'h03);
    for (int i = 0; i < NUM_COUNTERS; i++) begin
      if (i != SLOT_HOUR) begin
        wr(SLOT_IDX[i], cval[i]);
      end
    end
    wait_cyc(38);
    for (int i = 0; i < NUM_COUNTERS; i++) begin
      if (i != SLOT_HOUR) begin
        rd_chk(SLOT_IDX[i], cval[i]);
      end
    end
    check({24'h000000, cur_minutes}, 32'h00000059);
    check({24'h000000, cur_weekday}, 32'h00000006);
    wr(IDX_CTRL_ONE, 8'h18);
    poll_wait(1'b0);
    wr(IDX_CTRL_ONE, 8'h02);
    wait_cyc(40);
    rd_chk(IDX_CTRL_ONE, 8'h00);
    // Alarm match with enable off, then on
    alarm_time_match <= 1'b1;
    wait_cyc(48);
    rd_chk(IDX_CTRL_ONE, 8'h00);
    check(32'(irq_count), 32'h00000000);
    wr(IDX_CTRL_ONE, 8'h80);
    wait_cyc(48);
    rd_chk(IDX_CTRL_ONE, 8'h90);
    check(32'(irq_count), 32'h00000001);
    wr(IDX_CTRL_ONE, 8'h90);
    rd_chk(IDX_CTRL_ONE, 8'h90);
    wr(IDX_CTRL_ONE, 8'h80);
    rd_chk(IDX_CTRL_ONE, 8'h80);
    alarm_time_match <= 1'b0;
    wait_cyc(48);
    alarm_time_match <= 1'b1;
    wait_cyc(48);
    rd_chk(IDX_CTRL_ONE, 8'h90);
    check(32'(irq_count), 32'h00000002);
    // Full carry from seconds to month on a fast count clock
    cc_half = 1;
    wr(IDX_CTRL_ONE, 8'h00);
    wr(IDX_CTRL_ZERO, 8'h8B);
    rd_chk(IDX_HOURS, 8'h23);
    wait_cyc(2000);
    wr(IDX_SECONDS, 8'h59);
    wait_cyc(65400);
    rd_chk(IDX_SECONDS, 8'h59);
    wait_cyc(200);
    for (int i = 0; i < NUM_COUNTERS; i++) begin
      rd_chk(SLOT_IDX[i], nval[i]);
    end
    rd_chk(IDX_CTRL_ONE, 8'h08);
    check({24'h000000, cur_minutes}, 32'h00000000);
    check({24'h000000, cur_hours}, 32'h00000000);
    check({24'h000000, cur_weekday}, 32'h00000000);
    check(32'(irq_count), 32'h00000003);
    results();
  end
endmodule // testbench
